// ===== hdl/cdf_filters.sv
// Functional notes
// (R1) Record and playback paths each have their own filter pipeline.
// (R2) Four filter types 0 to 3 are selected per path by a type input.
// (R3) Group delay is 11/12 for type 0, 18/20 for type 1, 5/6 for type 3 (playback/record).
// (R4) A record-path high-pass stage removes dc and can be switched in or out.
// (R5) The high-pass stage computes y[n] = x[n] - x[n-1] + 0.9995*y[n-1].
// (R6) The pole of 0.9995 puts the single corner near 3.7 Hz at 48 kHz.
// (R7) Type 2 delays 5 samples on playback and 3 on record.
`timescale 1ns/1ps
`default_nettype none
module cdf_filters (
    input  wire logic                          core_clk_i,
    input  wire logic                          reset_n_i,
    input  wire logic                          fs_tick_i,
    input  wire logic [1:0]                    pb_type_i,
    input  wire logic [1:0]                    rc_type_i,
    input  wire logic                          hpf_en_i,
    input  wire logic                          pb_valid_i,
    output logic                               pb_ready_o,
    input  wire logic [cdf_pkg::SAMPLE_W-1:0]  pb_data_i,
    output logic                               pb_valid_o,
    output logic [cdf_pkg::SAMPLE_W-1:0]       pb_data_o,
    input  wire logic                          rc_valid_i,
    input  wire logic [cdf_pkg::SAMPLE_W-1:0]  rc_data_i,
    output logic                               rc_valid_o,
    output logic [cdf_pkg::SAMPLE_W-1:0]       rc_data_o
);
    localparam int unsigned W  = cdf_pkg::SAMPLE_W;
    localparam int unsigned N  = cdf_pkg::DLY_MAX;
    localparam int unsigned IW = cdf_pkg::DLY_IDX_W;
    localparam int unsigned AW = cdf_pkg::HPF_ACC_W;

    typedef struct packed {
        logic [N-1:0][W-1:0] pb_line;
        logic [N-1:0][W-1:0] rc_line;
        logic [W-1:0]        hp_x1;
        logic [AW-1:0]       hp_y1;
        cdf_pkg::cdf_smp_s   pb_out;
        cdf_pkg::cdf_smp_s   rc_out;
    } cdf_st_s;

    cdf_st_s              st_reg;
    cdf_st_s              st_next;
    logic                 fifo_valid;
    logic [W-1:0]         fifo_data;
    logic                 fifo_take;
    logic [IW-1:0]        pb_dly;
    logic [IW-1:0]        rc_dly;
    logic signed [AW-1:0] hp_acc;
    logic signed [AW-1:0] hp_prod;
    logic [W-1:0]         hp_out;
    logic [W-1:0]         rc_stage;
    logic [W-1:0]         pb_in;

    // playback words queue here; one drains per sample period
    cdf_fifo #(
        .WIDTH (W),
        .DEPTH (cdf_pkg::FIFO_DEPTH)
    ) u_pb_fifo (
        .core_clk_i  (core_clk_i),
        .reset_n_i   (reset_n_i),
        .in_valid_i  (pb_valid_i),
        .in_ready_o  (pb_ready_o),
        .in_data_i   (pb_data_i),
        .out_valid_o (fifo_valid),
        .out_ready_i (fifo_take),
        .out_data_o  (fifo_data)
    );

    // underrun feeds silence rather than stalling the modulator
    assign fifo_take = fs_tick_i; // R1
    assign pb_in     = fifo_valid ? fifo_data : cdf_pkg::SAMPLE_RST;

    // per-type group delay lookup for each path
    always_comb begin
        case (cdf_pkg::cdf_type_e'(pb_type_i)) // R2
            cdf_pkg::CDF_TYPE0: pb_dly = cdf_pkg::PB_DLY_T0; // R3
            cdf_pkg::CDF_TYPE1: pb_dly = cdf_pkg::PB_DLY_T1; // R3
            cdf_pkg::CDF_TYPE2: pb_dly = cdf_pkg::PB_DLY_T2; // R7
            cdf_pkg::CDF_TYPE3: pb_dly = cdf_pkg::PB_DLY_T3; // R3
            default:            pb_dly = cdf_pkg::PB_DLY_T0;
        endcase
        case (cdf_pkg::cdf_type_e'(rc_type_i)) // R2
            cdf_pkg::CDF_TYPE0: rc_dly = cdf_pkg::RC_DLY_T0; // R3
            cdf_pkg::CDF_TYPE1: rc_dly = cdf_pkg::RC_DLY_T1; // R3
            cdf_pkg::CDF_TYPE2: rc_dly = cdf_pkg::RC_DLY_T2; // R7
            cdf_pkg::CDF_TYPE3: rc_dly = cdf_pkg::RC_DLY_T3; // R3
            default:            rc_dly = cdf_pkg::RC_DLY_T0;
        endcase
    end

    // first-order dc blocker, pole product drops its 15 fraction bits, accumulator is whole samples
    always_comb begin
        hp_prod = AW'(($signed(st_reg.hp_y1) * $signed({1'b0, cdf_pkg::HPF_POLE}))
                  >>> cdf_pkg::HPF_FRAC); // R5 R6
        hp_acc  = AW'($signed(rc_data_i)) - AW'($signed(st_reg.hp_x1)) + hp_prod; // R5
        // saturate to the sample width, avoids wrap on large steps
        if (hp_acc > AW'($signed({1'b0, {(W-1){1'b1}}}))) begin
            hp_out = {1'b0, {(W-1){1'b1}}};
        end else if (hp_acc < AW'($signed({1'b1, {(W-1){1'b0}}}))) begin
            hp_out = {1'b1, {(W-1){1'b0}}};
        end else begin
            hp_out = hp_acc[W-1:0];
        end
        rc_stage = hpf_en_i ? hp_out : rc_data_i; // R4
    end

    // separate delay lines shift one sample per sample period
    always_comb begin
        st_next = st_reg;
        st_next.pb_out.valid = 1'b0;
        st_next.rc_out.valid = 1'b0;
        if (fs_tick_i) begin
            st_next.pb_line = {st_reg.pb_line[N-2:0], pb_in}; // R1
            st_next.pb_out.data  = st_reg.pb_line[pb_dly - IW'(1)];
            st_next.pb_out.valid = 1'b1;
        end
        if (rc_valid_i) begin
            st_next.rc_line = {st_reg.rc_line[N-2:0], rc_stage}; // R1
            st_next.rc_out.data  = st_reg.rc_line[rc_dly - IW'(1)];
            st_next.rc_out.valid = 1'b1;
            if (hpf_en_i) begin
                st_next.hp_x1 = rc_data_i; // R5
                st_next.hp_y1 = hp_acc; // R5
            end else begin
                // bypass clears history so re-enable starts clean
                st_next.hp_x1 = '0; // R4
                st_next.hp_y1 = '0;
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign pb_valid_o = st_reg.pb_out.valid;
    assign pb_data_o  = st_reg.pb_out.data;
    assign rc_valid_o = st_reg.rc_out.valid;
    assign rc_data_o  = st_reg.rc_out.data;
endmodule
`default_nettype wire

// ===== hdl/cdf_pkg.sv
package cdf_pkg;
    // sample width of both paths
    localparam int unsigned SAMPLE_W = 24;
    localparam int unsigned FIFO_DEPTH = 4;
    localparam int unsigned DLY_MAX = 32;
    localparam int unsigned DLY_IDX_W = 5;

    // group delay in sample periods, per filter type
    localparam logic [4:0] PB_DLY_T0 = 5'h0b;
    localparam logic [4:0] PB_DLY_T1 = 5'h12;
    localparam logic [4:0] PB_DLY_T2 = 5'h05;
    localparam logic [4:0] PB_DLY_T3 = 5'h05;
    localparam logic [4:0] RC_DLY_T0 = 5'h0c;
    localparam logic [4:0] RC_DLY_T1 = 5'h14;
    localparam logic [4:0] RC_DLY_T2 = 5'h03;
    localparam logic [4:0] RC_DLY_T3 = 5'h06;

    // high-pass pole 0.9995 in q1.15: 0.9995*32768 = 32751.6 -> 32752
    localparam int unsigned HPF_COEF_W = 16;
    localparam logic [15:0] HPF_POLE = 16'h7ff0;
    localparam int unsigned HPF_FRAC = 15;
    localparam int unsigned HPF_ACC_W = 48;

    // reset values
    localparam logic [23:0] SAMPLE_RST = 24'h000000;
    localparam logic [1:0] TYPE_RST = 2'h0;

    typedef enum logic [1:0] {
        CDF_TYPE0,
        CDF_TYPE1,
        CDF_TYPE2,
        CDF_TYPE3
    } cdf_type_e;

    typedef struct packed {
        logic        valid;
        logic [23:0] data;
    } cdf_smp_s;
endpackage

// ===== hdl/cdf_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module cdf_fifo #(
    parameter int unsigned WIDTH = 24,
    parameter int unsigned DEPTH = 4
) (
    input  wire logic             core_clk_i,
    input  wire logic             reset_n_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic [WIDTH-1:0]      out_data_o
);
    localparam int unsigned AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wr;
        logic [AW-1:0]               rd;
        logic [AW:0]                 cnt;
    } cdf_fifo_s;

    cdf_fifo_s st_reg;
    cdf_fifo_s st_next;
    logic      push;
    logic      pop;

    // honest full and empty from the occupancy count
    assign in_ready_o  = (st_reg.cnt != (AW+1)'(DEPTH));
    assign out_valid_o = (st_reg.cnt != '0);
    assign out_data_o  = st_reg.mem[st_reg.rd];
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_valid_o & out_ready_i;

    // pointer wrap relies on a power-of-two depth
    always_comb begin
        st_next = st_reg;
        if (push) begin
            st_next.mem[st_reg.wr] = in_data_i;
            st_next.wr = st_reg.wr + AW'(1);
        end
        if (pop) begin
            st_next.rd = st_reg.rd + AW'(1);
        end
        st_next.cnt = st_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end
endmodule
`default_nettype wire

// ===== verif/cdf_filters_props.sv
`timescale 1ns/1ps
`default_nettype none
module cdf_filters_props (
    input wire logic        core_clk_i,
    input wire logic        reset_n_i,
    input wire logic        fs_tick_i,
    input wire logic        rc_valid_i,
    input wire logic        pb_ready_o,
    input wire logic        pb_valid_o,
    input wire logic [23:0] pb_data_o,
    input wire logic        rc_valid_o
);
    // one clock domain, so one clocking and reset for all
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!reset_n_i);

    a_pb_tick_out: assert property (fs_tick_i |=> pb_valid_o)
        else $error("playback output missing after tick");
    a_pb_out_cause: assert property (pb_valid_o |-> $past(fs_tick_i))
        else $error("playback output without tick");
    a_rc_tick_out: assert property (rc_valid_i |=> rc_valid_o)
        else $error("record output missing after strobe");
    a_rc_out_cause: assert property (rc_valid_o |-> $past(rc_valid_i))
        else $error("record output without strobe");
    a_pb_data_stands: assert property (!fs_tick_i |=> $stable(pb_data_o))
        else $error("playback word changed between ticks");
    // full can only clear through a pop
    a_fifo_full_hold: assert property (!pb_ready_o && !fs_tick_i |=> !pb_ready_o)
        else $error("full flag cleared without pop");
    a_fifo_pop_frees: assert property (!pb_ready_o && fs_tick_i |=> pb_ready_o)
        else $error("pop on full buffer left it full");
endmodule

bind cdf_filters cdf_filters_props u_props (
    .core_clk_i, .reset_n_i, .fs_tick_i, .rc_valid_i,
    .pb_ready_o, .pb_valid_o, .pb_data_o, .rc_valid_o
);
`default_nettype wire

// ===== verif/cdf_conv_model.sv
`timescale 1ns/1ps
`default_nettype none
module cdf_conv_model #(
    parameter int unsigned PER = 16
) (
    input  wire logic        core_clk_i,
    input  wire logic        reset_n_i,
    input  wire logic [23:0] smp_i,
    output logic             tick_o,
    output logic [23:0]      data_o
);
    logic [4:0] cnt_reg;

    // one strobe per sample period, record word only valid with it
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cnt_reg <= 5'h00;
            tick_o  <= 1'b0;
            data_o  <= 24'h000000;
        end else begin
            cnt_reg <= (cnt_reg == PER - 1) ? 5'h00 : cnt_reg + 5'h01;
            tick_o  <= (cnt_reg == PER - 1);
            data_o  <= (cnt_reg == PER - 1) ? smp_i : ~data_o; // no stale word off strobe
        end
    end
endmodule
`default_nettype wire

// ===== verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fail_count++; \
    $display("MISMATCH %0t got %h exp %h", $time, a, b); end end
module testbench;
    logic        clk = 1'b0, rst_n = 1'b0, tick, pbv = 1'b0, hpf = 1'b0, pb_rdy, pbvo, rcvo;
    logic [1:0]  pbt = 2'h0, rct = 2'h0;
    logic [23:0] pbd = 24'h000000, smp = 24'h000000, rcd, pbdo, rcdo, e, pe, re;
    logic [23:0] pbh[$], rch[$], fq[$], pbq[$], rcq[$];
    logic [4:0]  pdl[4] = '{5'h0b, 5'h12, 5'h05, 5'h05};
    logic [4:0]  rdl[4] = '{5'h0c, 5'h14, 5'h03, 5'h06};
    logic [31:0] rs = 32'hd461;
    int          fail_count = 0, total_checks = 0, cyc = 0, w = 0;
    longint      x, y, x1 = 0, y1 = 0;

    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        v ^= v << 5;
        return v;
    endfunction
    // entry made d ticks before the newest one, zero before the first
    function automatic logic [23:0] pick(ref logic [23:0] h[$], input logic [4:0] d);
        return (h.size() > d) ? h[h.size() - 1 - d] : 24'h000000;
    endfunction
    task automatic test_done;
        if (fail_count == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    cdf_conv_model u_conv (.core_clk_i(clk), .reset_n_i(rst_n), .smp_i(smp), .tick_o(tick),
        .data_o(rcd));
    cdf_filters DUT (.core_clk_i(clk), .reset_n_i(rst_n), .fs_tick_i(tick), .pb_type_i(pbt),
        .rc_type_i(rct), .hpf_en_i(hpf), .pb_valid_i(pbv), .pb_ready_o(pb_rdy), .pb_data_i(pbd),
        .pb_valid_o(pbvo), .pb_data_o(pbdo), .rc_valid_i(tick), .rc_data_i(rcd),
        .rc_valid_o(rcvo), .rc_data_o(rcdo));

    initial forever #2.5 clk = ~clk;

    // driver: bursts of up to 7 words after each tick overfill the 4-word buffer
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3000) begin
            @(posedge clk);
            rs = xs(rs);
            smp <= {{3{rs[20]}}, rs[20:0]};
            `CHK(pb_rdy, 1'(fq.size() < 4))
            // pop before push: a word taken at this edge is not yet visible to the tick
            e = (tick && fq.size() > 0) ? fq.pop_front() : 24'h000000;
            if (pbv && pb_rdy) fq.push_back(pbd);
            // a refused word stays offered until the buffer takes it
            if (!pbv || pb_rdy) begin
                pbv <= (w > 0);
                pbd <= rs[31:8];
                if (w > 0) w--;
            end
            if (tick) begin
                pbh.push_back(e);
                pbq.push_back(pick(pbh, pdl[pbt]));
                x = $signed(rcd);
                y = hpf ? x - x1 + ((y1 * 16'sh7ff0) >>> 15) : x;
                x1 = hpf ? x : 0;
                y1 = hpf ? y : 0;
                rch.push_back(y[23:0]);
                rcq.push_back(pick(rch, rdl[rct]));
                w = int'(rs[7:5]);
                pbt <= rs[1:0];
                rct <= rs[3:2];
                hpf <= rs[4] | rs[9];
            end
        end
        test_done();
    end

    // monitor: oldest expectation against each output pulse
    always @(posedge clk) begin
        // pop once into a holder, the macro names its expectation twice
        if (pbvo) begin
            pe = pbq.pop_front();
            `CHK(pbdo, pe)
        end
        if (rcvo) begin
            re = rcq.pop_front();
            `CHK(rcdo, re)
        end
    end

    // hang guard, well above the 3010 cycles of the run
    always @(posedge clk) begin
        cyc++;
        if (cyc > 5000) begin
            fail_count++;
            test_done();
        end
    end
endmodule
`default_nettype wire
